// [inc/pfsw_pkg.sv]
package pfsw_pkg;
	localparam int unsigned ROW_INSNS      = 32;
	localparam int unsigned ROW_BYTES      = 96;
	localparam int unsigned PANEL_ROWS     = 128;
	localparam int unsigned INSN_BITS      = 24;
	localparam int unsigned CLK_HZ         = 100_000_000;
	localparam int unsigned OP_TIME_US     = 2000;
	localparam int unsigned OP_CYCLES      = OP_TIME_US * (CLK_HZ / 1_000_000);
	localparam int unsigned TBL_WRITE_CYCLES = 2;
	// Register indices on the device side of the link.
	localparam logic [1:0] REG_CONTROL     = 2'h0;
	localparam logic [1:0] REG_ADDR_LOW    = 2'h1;
	localparam logic [1:0] REG_ADDR_UPPER  = 2'h2;
	localparam logic [1:0] REG_UNLOCK_KEY  = 2'h3;
	// Control register fields.
	localparam int unsigned CTL_START_BIT  = 15;
	localparam int unsigned CTL_PERMIT_BIT = 14;
	localparam int unsigned CTL_ERROR_BIT  = 13;
	localparam int unsigned CTL_OP_MSB     = 6;
	localparam logic [15:0] CTL_RESET      = 16'h0000;
	localparam logic [6:0]  OP_ROW_ERASE   = 7'h41;
	localparam logic [6:0]  OP_ROW_PROGRAM = 7'h01;
	localparam logic [7:0]  KEY_FIRST      = 8'h55;
	localparam logic [7:0]  KEY_SECOND     = 8'haa;
	// Host command register map.
	localparam logic [3:0] CMD_REG_WRITE   = 4'h0;
	localparam logic [3:0] CMD_TBL_WRITE   = 4'h1;
	localparam logic [3:0] CMD_TBL_READ    = 4'h2;
	localparam logic [3:0] CMD_STATUS      = 4'h3;
	localparam logic [3:0] CMD_TBL_PAGE    = 4'h4;
	localparam logic [3:0] CMD_TBL_ADDR    = 4'h5;
	localparam logic [3:0] CMD_DEV_READ    = 4'h6;

	typedef enum logic [1:0] {
		PFSW_IDLE,
		PFSW_BUSY
	} pfsw_state_t;

	function automatic logic [23:0] pfsw_full_addr(input logic [7:0] page,
		input logic [15:0] ea);
		pfsw_full_addr = {page, ea};
	endfunction : pfsw_full_addr
endpackage : pfsw_pkg

// [inc/pfsw_if.sv]
`timescale 1ns/10ps
interface pfsw_if;
	logic        tbl_write;
	logic        tbl_read;
	logic        tbl_high;
	logic        tbl_byte;
	logic [7:0]  tbl_page;
	logic [15:0] tbl_ea;
	logic [15:0] tbl_wdata;
	logic [15:0] tbl_rdata;
	logic        tbl_done;
	logic        reg_write;
	logic        reg_read;
	logic [1:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic        core_stall;

	modport device (
		input  tbl_write, tbl_read, tbl_high, tbl_byte, tbl_page, tbl_ea,
		       tbl_wdata, reg_write, reg_read, reg_addr, reg_wdata,
		output tbl_rdata, tbl_done, core_stall, reg_rdata
	);
	modport core (
		output tbl_write, tbl_read, tbl_high, tbl_byte, tbl_page, tbl_ea,
		       tbl_wdata, reg_write, reg_read, reg_addr, reg_wdata,
		input  tbl_rdata, tbl_done, core_stall, reg_rdata
	);
endinterface : pfsw_if

// [hw/pfsw_op_timer.sv]
`timescale 1ns/10ps
module pfsw_op_timer
	import pfsw_pkg::*;
#(
	parameter int unsigned CYCLES = OP_CYCLES
)(
	input  wire logic clock,
	input  wire logic reset,
	input  wire logic start,
	output logic      busy,
	output logic      done
);
	typedef struct packed {
		logic [31:0] count;
		logic        busy;
		logic        done;
	} pfsw_tmr_t;

	pfsw_tmr_t s_q;
	pfsw_tmr_t s_d;

	always_comb
	begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (s_q.busy)
		begin
			if (s_q.count <= 32'd1)
			begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
			else
				s_d.count = s_q.count - 32'd1;
		end
		else if (start)
		begin
			s_d.busy  = 1'b1;
			s_d.count = (CYCLES == 0) ? 32'd1 : 32'(CYCLES);
		end
	end

	always_ff @(posedge clock)
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;

	assign busy = s_q.busy;
	assign done = s_q.done;
endmodule : pfsw_op_timer

// [hw/pfsw_device.sv]
`timescale 1ns/10ps
module pfsw_device
	import pfsw_pkg::*;
#(
	parameter int unsigned OP_LEN = OP_CYCLES,
	parameter int unsigned ROWS   = 4 * PANEL_ROWS
)(
	input  wire logic    clock,
	input  wire logic    reset,
	pfsw_if.device       link,
	output logic         op_active,
	output logic         op_error
);
	localparam int unsigned AW = $clog2(ROWS * ROW_INSNS);

	// Two address units per instruction; the word index drops bit 0.
	function automatic logic [AW-1:0] insn_index(input logic [23:0] addr);
		insn_index = AW'(addr >> 1);
	endfunction : insn_index

	// Flash array and panel write latches; one latch set covers the row.
	logic [INSN_BITS-1:0] flash_mem [ROWS*ROW_INSNS];
	logic [INSN_BITS-1:0] latch_mem [ROW_INSNS];

	typedef struct packed {
		pfsw_state_t state;
		logic [15:0] control;
		logic [15:0] addr_low;
		logic [7:0]  addr_upper;
		logic        key_first_seen;
		logic        unlocked;
		logic [15:0] rdata;
		logic [15:0] tbl_rdata;
		logic        tbl_phase;
		logic        tbl_done;
	} pfsw_dev_t;

	pfsw_dev_t s_q;
	pfsw_dev_t s_d;
	logic      tmr_start;
	logic      tmr_busy;
	logic      tmr_done;
	logic [23:0] tbl_addr;
	logic [AW-1:0] row_base;
	logic [4:0]  lat_idx;

	assign tbl_addr = pfsw_full_addr(link.tbl_page, link.tbl_ea);
	// Program addresses step by two per instruction; bits 5:1 pick the latch.
	assign lat_idx  = tbl_addr[5:1];
	assign row_base = AW'({s_q.addr_upper, s_q.addr_low[15:6], 5'h00});

	// The core stall follows the timer from the cycle after the start, so only a command
	// the core took in the start cycle can still change the latches and address registers while a row is being written.
	pfsw_op_timer #(
		.CYCLES (OP_LEN)
	) u_timer (
		.clock (clock),
		.reset (reset),
		.start (tmr_start),
		.busy  (tmr_busy),
		.done  (tmr_done)
	);

	always_comb
	begin
		s_d          = s_q;
		s_d.tbl_done = 1'b0;
		tmr_start    = 1'b0;
		if (link.tbl_write || link.tbl_read)
		begin
			s_d.addr_low   = tbl_addr[15:0];
			s_d.addr_upper = tbl_addr[23:16];
			s_d.tbl_phase  = ~s_q.tbl_phase;
			s_d.tbl_done   = s_q.tbl_phase;
		end
		if (link.tbl_read)
			s_d.tbl_rdata = link.tbl_high ?
				{8'h00, flash_mem[insn_index(tbl_addr)][23:16]} :
				flash_mem[insn_index(tbl_addr)][15:0];
		// The key reads as zero so that it cannot be learnt back.
		if (link.reg_read)
			unique case (link.reg_addr)
				REG_CONTROL:    s_d.rdata = s_q.control;
				REG_ADDR_LOW:   s_d.rdata = s_q.addr_low;
				REG_ADDR_UPPER: s_d.rdata = {8'h00, s_q.addr_upper};
				REG_UNLOCK_KEY: s_d.rdata = 16'h0000;
			endcase
		if (link.reg_write)
		begin
			s_d.key_first_seen = 1'b0;
			s_d.unlocked       = 1'b0;
			unique case (link.reg_addr)
				REG_CONTROL:
				begin
					s_d.control[CTL_PERMIT_BIT] = link.reg_wdata[CTL_PERMIT_BIT];
					s_d.control[CTL_OP_MSB:0]   = link.reg_wdata[CTL_OP_MSB:0];
					if (link.reg_wdata[CTL_START_BIT] && s_q.state == PFSW_IDLE)
					begin
						// A start without a fresh unlock is flagged, not run.
						if (s_q.unlocked && link.reg_wdata[CTL_PERMIT_BIT])
						begin
							s_d.control[CTL_START_BIT] = 1'b1;
							s_d.state = PFSW_BUSY;
							tmr_start = 1'b1;
						end
						else
							s_d.control[CTL_ERROR_BIT] = 1'b1;
					end
					if (!link.reg_wdata[CTL_ERROR_BIT])
						s_d.control[CTL_ERROR_BIT] = s_d.control[CTL_ERROR_BIT]
							& ~(s_q.control[CTL_ERROR_BIT] & ~link.reg_wdata[CTL_START_BIT]);
				end
				REG_ADDR_LOW:   s_d.addr_low   = link.reg_wdata;
				REG_ADDR_UPPER: s_d.addr_upper = link.reg_wdata[7:0];
				// Every write clears the pair above before the key check, so a
				// stray write between the keys leaves the device locked.
				REG_UNLOCK_KEY:
				begin
					if (link.reg_wdata[7:0] == KEY_FIRST)
						s_d.key_first_seen = 1'b1;
					else if (s_q.key_first_seen && link.reg_wdata[7:0] == KEY_SECOND)
						s_d.unlocked = 1'b1;
				end
			endcase
		end
		unique case (s_q.state)
			PFSW_IDLE: ;
			PFSW_BUSY:
			begin
				// An unlock made during a run is spent here, never kept.
				s_d.unlocked = 1'b0;
				if (tmr_done)
				begin
					s_d.control[CTL_START_BIT] = 1'b0;
					s_d.state = PFSW_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock)
		if (reset)
		begin
			s_q         <= '0;
			s_q.control <= CTL_RESET;
			s_q.state   <= PFSW_IDLE;
		end
		else
			s_q <= s_d;

	// Array storage has no reset; its contents survive like real cells.
	always_ff @(posedge clock)
	begin
		if (link.tbl_write && !link.tbl_high)
		begin
			// Byte mode reaches the low word only; address bit 0 picks the byte.
			if (link.tbl_byte)
			begin
				if (tbl_addr[0])
					latch_mem[lat_idx][15:8] <= link.tbl_wdata[7:0];
				else
					latch_mem[lat_idx][7:0] <= link.tbl_wdata[7:0];
			end
			else
				latch_mem[lat_idx][15:0] <= link.tbl_wdata;
		end
		if (link.tbl_write && link.tbl_high)
			latch_mem[lat_idx][23:16] <= link.tbl_wdata[7:0];
		// The row is written when the timer ends; erase ignores the latches
		// and leaves every cell at its blank level.
		if (tmr_done)
			for (int i = 0; i < ROW_INSNS; i++)
				flash_mem[row_base + AW'(i)] <=
					(s_q.control[CTL_OP_MSB:0] == OP_ROW_ERASE) ?
					{INSN_BITS{1'b1}} : latch_mem[i];
	end

	// Outputs come straight from registers, so they hold steady all cycle.
	assign link.tbl_rdata  = s_q.tbl_rdata;
	assign link.tbl_done   = s_q.tbl_done;
	assign link.reg_rdata  = s_q.rdata;
	assign link.core_stall = tmr_busy;
	assign op_active       = tmr_busy;
	assign op_error        = s_q.control[CTL_ERROR_BIT];
endmodule : pfsw_device

// [hw/pfsw_core.sv]
`timescale 1ns/10ps
module pfsw_core
	import pfsw_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset,
	pfsw_if.core             link,
	input  wire logic [3:0]  cmd_addr,
	input  wire logic [15:0] cmd_wdata,
	input  wire logic        cmd_write,
	input  wire logic        cmd_read,
	output logic [15:0]      cmd_rdata
);
	typedef struct packed {
		logic        tbl_write;
		logic        tbl_read;
		logic        tbl_high;
		logic        tbl_byte;
		logic [7:0]  page;
		logic [15:0] ea;
		logic [15:0] wdata;
		logic        reg_write;
		logic        reg_read;
		logic [1:0]  reg_addr;
		logic        dev_read_pend;
		logic        tbl_read_pend;
		logic [15:0] dev_rdata;
		logic [15:0] rdata;
	} pfsw_core_t;

	pfsw_core_t s_q;
	pfsw_core_t s_d;

	// Write commands are dropped while stalled, as a stalled core issues nothing.
	always_comb
	begin
		s_d           = s_q;
		s_d.tbl_write = 1'b0;
		s_d.tbl_read  = 1'b0;
		s_d.reg_write = 1'b0;
		s_d.reg_read  = 1'b0;
		// Device read data stand one cycle after the strobe; capture there.
		if (s_q.dev_read_pend)
			s_d.dev_rdata = link.reg_rdata;
		if (s_q.tbl_read_pend)
			s_d.dev_rdata = link.tbl_rdata;
		s_d.dev_read_pend = s_q.reg_read;
		s_d.tbl_read_pend = s_q.tbl_read;
		if (cmd_read)
			unique case (cmd_addr)
				CMD_STATUS:   s_d.rdata = {15'h0000, link.core_stall};
				CMD_TBL_PAGE: s_d.rdata = {8'h00, s_q.page};
				CMD_TBL_ADDR: s_d.rdata = s_q.ea;
				default:      s_d.rdata = s_q.dev_rdata;
			endcase
		if (cmd_write && !link.core_stall)
			unique case (cmd_addr)
				CMD_REG_WRITE:
				begin
					s_d.reg_write = 1'b1;
					s_d.reg_addr  = cmd_wdata[15:14];
					s_d.wdata     = {2'b00, cmd_wdata[13:0]};
				end
				CMD_TBL_WRITE:
				begin
					s_d.tbl_write = 1'b1;
					s_d.tbl_high  = cmd_wdata[15];
					s_d.tbl_byte  = cmd_wdata[14];
					s_d.wdata     = cmd_wdata[14] ? {8'h00, cmd_wdata[7:0]} :
						{2'b00, cmd_wdata[13:0]};
				end
				CMD_TBL_READ:
				begin
					s_d.tbl_read = 1'b1;
					s_d.tbl_high = cmd_wdata[15];
				end
				CMD_TBL_PAGE: s_d.page = cmd_wdata[7:0];
				CMD_TBL_ADDR: s_d.ea   = cmd_wdata;
				CMD_DEV_READ:
				begin
					s_d.reg_read = 1'b1;
					s_d.reg_addr = cmd_wdata[1:0];
				end
				default: ;
			endcase
	end

	always_ff @(posedge clock)
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;

	assign link.tbl_write = s_q.tbl_write;
	assign link.tbl_read  = s_q.tbl_read;
	assign link.tbl_high  = s_q.tbl_high;
	assign link.tbl_byte  = s_q.tbl_byte;
	assign link.tbl_page  = s_q.page;
	assign link.tbl_ea    = s_q.ea;
	assign link.tbl_wdata = s_q.wdata;
	assign link.reg_write = s_q.reg_write;
	assign link.reg_read  = s_q.reg_read;
	assign link.reg_addr  = s_q.reg_addr;
	// Control data bits 13 and 12 also drive start and permit, which the
	// narrow command field cannot reach directly.
	assign link.reg_wdata = (s_q.reg_addr == REG_CONTROL) ?
		{s_q.wdata[13:12], s_q.wdata[13:0]} : s_q.wdata;
	assign cmd_rdata      = s_q.rdata;
endmodule : pfsw_core

// [testbench/pfsw_sva.sv]
`timescale 1ns/10ps
module pfsw_sva
	import pfsw_pkg::*;
#(
	parameter int unsigned OP_LEN = 20
)(
	input wire logic        clock,
	input wire logic        reset,
	input wire logic        tbl_write,
	input wire logic        tbl_read,
	input wire logic [7:0]  tbl_page,
	input wire logic [15:0] tbl_ea,
	input wire logic        tbl_done,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [1:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic        core_stall,
	input wire logic        op_error
);
	logic [1:0]  key_q;
	logic [1:0]  key_d;
	logic [15:0] ea_q;
	logic [7:0]  pg_q;
	logic [31:0] cnt_q;
	logic        kw;
	logic        st;
	logic        arm;
	logic        ph_q;
	logic        acc;

	assign acc   = (tbl_write || tbl_read) && ph_q;

	// Any register write other than the second key drops the unlock.
	assign kw    = reg_write && reg_addr == REG_UNLOCK_KEY;
	assign key_d = !kw ? 2'h0 : reg_wdata[7:0] == KEY_FIRST ? 2'h1 :
		(reg_wdata[7:0] == KEY_SECOND && key_q == 2'h1) ? 2'h2 : 2'h0;
	assign st    = reg_write && reg_addr == REG_CONTROL && reg_wdata[15];
	assign arm   = st && reg_wdata[14] && key_q == 2'h2 && !core_stall;

	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			key_q <= 2'h0;
			ea_q  <= 16'h0000;
			pg_q  <= 8'h00;
			cnt_q <= '0;
			ph_q  <= 1'b0;
		end
		else
		begin
			if (reg_write)
				key_q <= key_d;
			if (tbl_write || tbl_read)
			begin
				ph_q <= ~ph_q;
				ea_q <= tbl_ea;
				pg_q <= tbl_page;
			end
			if (reg_write && reg_addr == REG_ADDR_LOW)
				ea_q <= reg_wdata;
			if (reg_write && reg_addr == REG_ADDR_UPPER)
				pg_q <= reg_wdata[7:0];
			cnt_q <= core_stall ? cnt_q + 1 : '0;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	property p_unlock; arm |=> core_stall; endproperty
	property p_refuse; st && !arm && !core_stall |=> !core_stall; endproperty
	property p_err; st && !arm && !core_stall |-> ##[1:2] op_error; endproperty
	property p_len;
		$fell(core_stall) |-> cnt_q >= OP_LEN && cnt_q <= OP_LEN + 1;
	endproperty
	property p_bound; core_stall |-> cnt_q <= OP_LEN + 1; endproperty
	property p_clear;
		reg_read && reg_addr == REG_CONTROL && !core_stall &&
			!$past(core_stall) |=> !reg_rdata[15];
	endproperty
	property p_key;
		reg_read && reg_addr == REG_UNLOCK_KEY |=> reg_rdata == 16'h0000;
	endproperty
	property p_alo;
		reg_read && reg_addr == REG_ADDR_LOW |=> reg_rdata == $past(ea_q);
	endproperty
	property p_aup;
		reg_read && reg_addr == REG_ADDR_UPPER |=>
			reg_rdata[7:0] == $past(pg_q);
	endproperty
	property p_tbl; tbl_write && !core_stall |=> !core_stall; endproperty
	property p_done; tbl_done == $past(acc); endproperty

	a_unlock: assert property (p_unlock)
		else $error("unlocked start did not stall the core");
	a_refuse: assert property (p_refuse)
		else $error("start without unlock began an operation");
	a_err: assert property (p_err)
		else $error("refused start did not flag an error");
	a_len: assert property (p_len)
		else $error("operation length wrong");
	a_bound: assert property (p_bound)
		else $error("stall lasted too long");
	a_clear: assert property (p_clear)
		else $error("start bit still set while idle");
	a_key: assert property (p_key)
		else $error("unlock key register readable");
	a_alo: assert property (p_alo)
		else $error("low address not captured");
	a_aup: assert property (p_aup)
		else $error("upper address not captured");
	a_tbl: assert property (p_tbl)
		else $error("table write started an operation");
	a_done: assert property (p_done)
		else $error("table access done pulse wrong");

	c_start: cover property (arm);
	c_end: cover property ($fell(core_stall));
	c_refuse: cover property (st && !arm);
endmodule : pfsw_sva

// [testbench/program_flash_self_write_ctrl_tb.sv]
`timescale 1ns/10ps
module program_flash_self_write_ctrl_tb
	import pfsw_pkg::*;
;
	localparam int OPL = 20;
	logic        clock;
	logic        reset;
	logic [3:0]  cmd_addr;
	logic [15:0] cmd_wdata;
	logic        cmd_write;
	logic        cmd_read;
	logic [15:0] cmd_rdata;
	logic        op_active;
	logic        op_error;
	logic [15:0] d;
	logic [7:0]  bad [3] = '{8'h56, 8'h55, 8'haa};
	int          err_total = 0;
	int          n_tests = 0;

	pfsw_if link();
	pfsw_core i_pfsw_core (.clock(clock), .reset(reset), .link(link),
		.cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write),
		.cmd_read(cmd_read), .cmd_rdata(cmd_rdata));
	pfsw_device #(.OP_LEN(OPL)) i_pfsw_device (.clock(clock), .reset(reset),
		.link(link), .op_active(op_active), .op_error(op_error));
	pfsw_sva #(.OP_LEN(OPL)) i_pfsw_sva (.clock(clock), .reset(reset),
		.tbl_write(link.tbl_write), .tbl_read(link.tbl_read),
		.tbl_page(link.tbl_page), .tbl_ea(link.tbl_ea),
		.tbl_done(link.tbl_done),
		.reg_write(link.reg_write), .reg_read(link.reg_read),
		.reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
		.reg_rdata(link.reg_rdata), .core_stall(link.core_stall),
		.op_error(op_error));

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cmd_wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		cmd_addr  <= a;
		cmd_wdata <= v;
		cmd_write <= 1'b1;
		@(posedge clock);
		cmd_write <= 1'b0;
	endtask : cmd_wr

	// The core needs a few cycles to forward a command across the link.
	task automatic cmd_rd(input logic [3:0] a, output logic [15:0] v);
		repeat (4) @(posedge clock);
		cmd_addr <= a;
		cmd_read <= 1'b1;
		@(posedge clock);
		cmd_read <= 1'b0;
		#1 v = cmd_rdata;
	endtask : cmd_rd

	task automatic dev_wr(input logic [1:0] i, input logic [13:0] v);
		cmd_wr(CMD_REG_WRITE, {i, v});
		repeat (2) @(posedge clock);
	endtask : dev_wr

	task automatic unlock(input logic [7:0] k1, input logic gap);
		dev_wr(REG_UNLOCK_KEY, {6'h0, k1});
		if (gap)
			dev_wr(REG_ADDR_LOW, 14'h0040);
		dev_wr(REG_UNLOCK_KEY, {6'h0, KEY_SECOND});
	endtask : unlock

	task automatic no_op;
		logic [15:0] s;
		repeat (4) @(posedge clock);
		chk("no operation", {15'h0, op_active}, 16'h0000);
		chk("error flag", {15'h0, op_error}, 16'h0001);
		cmd_rd(CMD_STATUS, s);
		chk("stall status", s, 16'h0000);
	endtask : no_op

	task automatic wait_op;
		int n;
		n = 0;
		while (op_active !== 1'b1 && n < 10)
		begin
			@(posedge clock);
			n++;
		end
		n = 0;
		while (op_active === 1'b1 && n < OPL + 10)
		begin
			@(posedge clock);
			n++;
		end
		chk("op length", {15'h0, n >= OPL && n <= OPL + 2}, 16'h1);
	endtask : wait_op

	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Far above the several hundred cycles that the sequence needs.
	initial
	begin
		repeat (30000) @(posedge clock);
		err_total++;
		final_report;
	end

	initial
	begin
		reset     = 1'b1;
		cmd_addr  = 4'h0;
		cmd_wdata = 16'h0000;
		cmd_write = 1'b0;
		cmd_read  = 1'b0;
		repeat (16) @(posedge clock);
		reset <= 1'b0;
		cmd_wr(CMD_DEV_READ, {14'h0, REG_CONTROL});
		cmd_rd(CMD_DEV_READ, d);
		chk("control reset", d, CTL_RESET);
		cmd_wr(CMD_DEV_READ, {14'h0, REG_UNLOCK_KEY});
		cmd_rd(CMD_DEV_READ, d);
		chk("key read", d, 16'h0000);
		$display("reset test done");
		cmd_wr(CMD_TBL_PAGE, 16'h0012);
		cmd_wr(CMD_TBL_ADDR, 16'h6000);
		cmd_wr(CMD_TBL_WRITE, 16'h0123);
		cmd_wr(CMD_DEV_READ, {14'h0, REG_ADDR_LOW});
		cmd_rd(CMD_DEV_READ, d);
		chk("addr low", d, 16'h6000);
		cmd_wr(CMD_DEV_READ, {14'h0, REG_ADDR_UPPER});
		cmd_rd(CMD_DEV_READ, d);
		chk("addr upper", {8'h0, d[7:0]}, 16'h0012);
		cmd_rd(CMD_TBL_PAGE, d);
		chk("table page", d, 16'h0012);
		cmd_rd(CMD_TBL_ADDR, d);
		chk("table ea", d, 16'h6000);
		dev_wr(REG_ADDR_LOW, 14'h0040);
		cmd_wr(CMD_DEV_READ, {14'h0, REG_ADDR_LOW});
		cmd_rd(CMD_DEV_READ, d);
		chk("addr write", d, 16'h0040);
		$display("address test done");
		// The last pass has good keys but no write permit.
		for (int k = 0; k < 4; k++)
		begin
			unlock(k < 3 ? bad[k] : KEY_FIRST, k == 1);
			dev_wr(REG_CONTROL, k < 3 ? 14'h3041 : 14'h2041);
			no_op();
			dev_wr(REG_CONTROL, 14'h0041);
		end
		$display("refusal test done");
		cmd_wr(CMD_TBL_PAGE, 16'h0000);
		for (int i = 0; i < 32; i++)
		begin
			cmd_wr(CMD_TBL_ADDR, 16'h6000 + 16'(2 * i));
			cmd_wr(CMD_TBL_WRITE, {2'b00, 14'(3 * i + 1)});
			cmd_wr(CMD_TBL_WRITE, {8'h80, 8'(i + 128)});
		end
		dev_wr(REG_CONTROL, 14'h1001);
		unlock(KEY_FIRST, 1'b0);
		dev_wr(REG_CONTROL, 14'h3001);
		wait_op();
		cmd_wr(CMD_DEV_READ, {14'h0, REG_CONTROL});
		cmd_rd(CMD_DEV_READ, d);
		chk("start clear", {15'h0, d[15]}, 16'h0000);
		cmd_wr(CMD_TBL_ADDR, 16'h6000);
		cmd_wr(CMD_TBL_WRITE, 16'h1555);
		for (int i = 0; i < 32; i += 5)
		begin
			cmd_wr(CMD_TBL_ADDR, 16'h6000 + 16'(2 * i));
			cmd_wr(CMD_TBL_READ, 16'h0000);
			cmd_rd(CMD_TBL_READ, d);
			chk("row low", d, 16'(3 * i + 1));
			cmd_wr(CMD_TBL_READ, 16'h8000);
			cmd_rd(CMD_TBL_READ, d);
			chk("row high", {8'h0, d[7:0]}, 16'(i + 128));
		end
		$display("program test done");
		dev_wr(REG_CONTROL, 14'h1041);
		unlock(KEY_FIRST, 1'b0);
		dev_wr(REG_CONTROL, 14'h3041);
		wait_op();
		cmd_wr(CMD_TBL_ADDR, 16'h603e);
		cmd_wr(CMD_TBL_READ, 16'h0000);
		cmd_rd(CMD_TBL_READ, d);
		chk("erased low", d, 16'hffff);
		dev_wr(REG_CONTROL, 14'h3041);
		no_op();
		$display("erase test done");
		final_report;
	end
endmodule : program_flash_self_write_ctrl_tb
